// ==== logic/gauge_pkg.sv ====
// Contract
// - Enter relax after quiet current for relax time
// - Attempt OCV readings after five relaxed minutes
// - Capacity update only below 4 uV/s slope
// - Exit relax after current above quit time
// - Learned bit 0 set by device, host-writable
// - Store previous discharge cycle average current
// - Store previous discharge cycle average power
// - Configuration word lives at subclass 64 offset 0
// - Reserve compensation enable, default off
// - Good override keeps output during voltage hibernate
// - Removal raises 1 ms interrupt pulse when enabled
// - Decode two-bit pin function, default mode 1
// - Wake and sense bits configure wake, 0/0/1
// - Interrupt held during first OCV when enabled
// - Profile, sleep, reload, thermistor bits default set
// - Pin polarity bits, interrupt and good active-low
// - Host temperature write enable, default off
// - Insertion detect off means host sets detected
// - Ground select defaults set, low irq off
// - Early good asserts output during initialization
// - Mode 1 temperature gating, mode 2 shares thermistor
// - Low output follows low-charge flag with polarity
// - Low-charge flag set below, cleared above threshold
`default_nettype none
package gauge_pkg;
	localparam int SYS_CLK_HZ = 25_000_000;
	localparam int REMOVE_PULSE_MS = 1;
	localparam int MS_CYCLES = SYS_CLK_HZ / 1000 * REMOVE_PULSE_MS;
	localparam int SEC_CYCLES = SYS_CLK_HZ;
	// Cycles a snapshot stays put after a toggle, well over the link-side capture time
	localparam logic [2:0] SNAP_HOLD = 3'h7;
	localparam logic [15:0] OCV_WAIT_S = 16'h012c;
	localparam logic [15:0] DVDT_LIMIT_UV = 16'h0004;
	// Byte offsets inside the configuration subclass
	localparam logic [7:0] CFG_SUBCLASS = 8'h40;
	localparam logic [7:0] OFS_CFG_HI = 8'h00;
	localparam logic [7:0] OFS_CFG_LO = 8'h01;
	localparam logic [7:0] OFS_CFG_B = 8'h09;
	localparam logic [7:0] OFS_LEARN0 = 8'h20;
	localparam logic [7:0] OFS_LEARN1 = 8'h21;
	// Values after reset and write masks
	localparam logic [15:0] CFG_WORD_RST = 16'h0973;
	localparam logic [7:0] CFG_B_RST = 8'h50;
	localparam logic [7:0] CFG_B_MASK = 8'hf8;
	localparam logic [7:0] LEARN_MASK = 8'h01;
	// Configuration word fields
	localparam int B_RESERVE = 15;
	localparam int B_OVERRIDE = 14;
	localparam int B_REMOVAL = 13;
	localparam int B_FUNC_HI = 12;
	localparam int B_FUNC_LO = 11;
	localparam int B_WAKE = 10;
	localparam int B_SENSE_HI = 9;
	localparam int B_SENSE_LO = 8;
	localparam int B_FIRST_OCV = 7;
	localparam int B_PROFILE = 6;
	localparam int B_SLEEP = 5;
	localparam int B_RELOAD = 4;
	localparam int B_IRQ_POL = 3;
	localparam int B_GOOD_POL = 2;
	localparam int B_LOW_POL = 1;
	localparam int B_THERM = 0;
	// Second configuration byte fields
	localparam int B_HOST_TEMP = 7;
	localparam int B_INSERT = 6;
	localparam int B_LOW_IRQ = 5;
	localparam int B_GROUND = 4;
	localparam int B_EARLY_GOOD = 3;
	typedef enum logic [1:0] {FUNC_MODE0 = 2'h0, FUNC_MODE1 = 2'h1, FUNC_MODE2 = 2'h2} func_mode_t;
endpackage
`default_nettype wire

// ==== logic/cfg_link_if.sv ====
`default_nettype none
// Carries byte writes from the link domain and configuration snapshots back
interface cfg_link_if;
	logic wr_tgl;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic ack_tgl;
	logic snap_tgl;
	logic [39:0] snap;
	modport link_end (output wr_tgl, wr_addr, wr_data, input ack_tgl, snap_tgl, snap);
	modport sys_end (input wr_tgl, wr_addr, wr_data, output ack_tgl, snap_tgl, snap);
endinterface
`default_nettype wire

// ==== logic/link_port.sv ====
`default_nettype none
module link_port (
	// Link side
	input wire logic i_link_clk,
	input wire logic i_rst_n,
	input wire logic i_wr,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic o_busy,
	// Towards the system domain
	cfg_link_if.link_end lnk
);
	logic ack_s1_r, ack_s2_r, snap_s1_r, snap_s2_r, snap_seen_r;
	logic [39:0] shadow_r;

	// Two-flop synchronisers for the toggles coming back
	always_ff @(posedge i_link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
			snap_s1_r <= 1'b0;
			snap_s2_r <= 1'b0;
			snap_seen_r <= 1'b0;
		end else begin
			ack_s1_r <= lnk.ack_tgl;
			ack_s2_r <= ack_s1_r;
			snap_s1_r <= lnk.snap_tgl;
			snap_s2_r <= snap_s1_r;
			snap_seen_r <= snap_s2_r;
		end
	end

	// One write in flight; a write while busy is dropped so nothing tears
	always_ff @(posedge i_link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lnk.wr_tgl <= 1'b0;
			lnk.wr_addr <= 8'h00;
			lnk.wr_data <= 8'h00;
			o_busy <= 1'b0;
		end else if (i_wr && !o_busy) begin
			lnk.wr_tgl <= ~lnk.wr_tgl;
			lnk.wr_addr <= i_addr;
			lnk.wr_data <= i_wdata;
			o_busy <= 1'b1;
		end else if (ack_s2_r == lnk.wr_tgl) begin
			o_busy <= 1'b0;
		end
	end

	// Snapshot is stable long before its toggle arrives here
	always_ff @(posedge i_link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			shadow_r <= {gauge_pkg::CFG_WORD_RST, gauge_pkg::CFG_B_RST, 16'h0000};
		end else if (snap_s2_r != snap_seen_r) begin
			shadow_r <= lnk.snap;
		end
	end

	// Registered read data, unmapped offsets read zero
	always_ff @(posedge i_link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
		end else begin
			unique case (i_addr)
				gauge_pkg::OFS_CFG_HI: o_rdata <= shadow_r[39:32];
				gauge_pkg::OFS_CFG_LO: o_rdata <= shadow_r[31:24];
				gauge_pkg::OFS_CFG_B: o_rdata <= shadow_r[23:16];
				gauge_pkg::OFS_LEARN0: o_rdata <= shadow_r[15:8];
				gauge_pkg::OFS_LEARN1: o_rdata <= shadow_r[7:0];
				default: o_rdata <= 8'h00;
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== logic/pulse_stretch.sv ====
`default_nettype none
module pulse_stretch #(
	parameter int LEN = 16
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	output logic o_active
);
	localparam int CW = $clog2(LEN + 1);
	logic [CW-1:0] cnt_r;

	// Retrigger during a pulse is ignored so the width stays exact
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= '0;
		end else if (i_start && cnt_r == '0) begin
			cnt_r <= CW'(LEN);
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end
	assign o_active = (cnt_r != '0);
endmodule
`default_nettype wire

// ==== logic/gauge_config_pin_control.sv ====
`default_nettype none
module gauge_config_pin_control #(
	parameter int SEC_CYCLES_P = gauge_pkg::SEC_CYCLES,
	parameter int MS_CYCLES_P = gauge_pkg::MS_CYCLES
) (
	// System clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Serial link register port
	input wire logic i_link_clk,
	input wire logic i_link_wr,
	input wire logic [7:0] i_link_addr,
	input wire logic [7:0] i_link_wdata,
	output logic [7:0] o_link_rdata,
	output logic o_link_busy,
	// Gauging measurements
	input wire logic signed [15:0] i_averaged_current,
	input wire logic [15:0] i_quit_current,
	input wire logic [15:0] i_dsg_relax_s,
	input wire logic [15:0] i_chg_relax_s,
	input wire logic [15:0] i_quit_relax_s,
	input wire logic [15:0] i_dv_dt,
	input wire logic signed [15:0] i_inst_current,
	input wire logic [15:0] i_voltage,
	input wire logic i_dsg_active,
	input wire logic [15:0] i_remaining_cap,
	input wire logic [15:0] i_low_set_thr,
	input wire logic [1:0] i_learned,
	// Gauge state events
	input wire logic i_init_active,
	input wire logic i_first_ocv_active,
	input wire logic i_ocv_done,
	input wire logic i_hibernate,
	input wire logic i_hib_voltage_only,
	input wire logic i_charging,
	input wire logic i_chg_temp_bad,
	input wire logic i_batt_removed,
	input wire logic i_insert_seen,
	input wire logic i_host_det_cmd,
	// Relaxation, logging and low-charge results
	output logic o_relax,
	output logic o_ocv_attempt,
	output logic o_qmax_update,
	output logic [15:0] o_avg_i_last,
	output logic [31:0] o_avg_p_last,
	output logic o_low_charge_flag,
	// Pins
	output logic o_battery_low_out,
	output logic o_battery_good_out,
	output logic o_soc_int_out,
	// Decoded configuration and battery detected status
	output logic [1:0] o_pin_function_code,
	output logic [2:0] o_wake_cfg,
	output logic o_reserve_comp_en,
	output logic o_profile_select_en,
	output logic o_sleep_en,
	output logic o_capacity_reload_on_term,
	output logic o_ext_thermistor_sel,
	output logic o_host_temp_write_en,
	output logic o_low_batt_irq_en,
	output logic o_adc_ground_sel,
	output logic o_thermistor_to_charger,
	output logic o_battery_detected_bit
);
	typedef enum logic {ST_ACTIVE = 1'b0, ST_RELAX = 1'b1} relax_state_t;
	cfg_link_if lnk ();

	logic [15:0] cfg_word_r;
	logic [7:0] cfg_b_r, learn0_r, learn1_r;
	logic wr_s1_r, wr_s2_r, wr_seen_r;
	logic [31:0] sec_cnt_r;
	logic sec_tick_r;
	relax_state_t state_r;
	logic [15:0] below_r, above_r, relax_secs_r, abs_avg;
	logic last_chg_r, quiet, enter_now, exit_now;
	logic dsg_prev_r, dsg_end;
	logic signed [39:0] sum_i_r;
	logic signed [56:0] sum_p_r;
	logic [23:0] samples_r;
	logic signed [32:0] inst_power;
	logic removal_active, irq_active, good_active;
	logic wr_event;
	logic [2:0] snap_hold_r;

	link_port u_link (
		.i_link_clk(i_link_clk),
		.i_rst_n(i_rst_n),
		.i_wr(i_link_wr),
		.i_addr(i_link_addr),
		.i_wdata(i_link_wdata),
		.o_rdata(o_link_rdata),
		.o_busy(o_link_busy),
		.lnk(lnk.link_end)
	);

	pulse_stretch #(.LEN(MS_CYCLES_P)) u_removal (
		.i_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_start(i_batt_removed && cfg_word_r[gauge_pkg::B_REMOVAL]),
		.o_active(removal_active)
	);

	// Write toggle synchroniser; only the second stage is compared
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_s1_r <= 1'b0;
			wr_s2_r <= 1'b0;
			wr_seen_r <= 1'b0;
		end else begin
			wr_s1_r <= lnk.wr_tgl;
			wr_s2_r <= wr_s1_r;
			wr_seen_r <= wr_s2_r;
		end
	end
	assign wr_event = wr_s2_r != wr_seen_r;
	assign lnk.ack_tgl = wr_seen_r;

	// Working configuration: defaults at reset, byte writes from the host
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cfg_word_r <= gauge_pkg::CFG_WORD_RST;
			cfg_b_r <= gauge_pkg::CFG_B_RST;
		end else if (wr_event) begin
			unique case (lnk.wr_addr)
				gauge_pkg::OFS_CFG_HI: cfg_word_r[15:8] <= lnk.wr_data;
				gauge_pkg::OFS_CFG_LO: cfg_word_r[7:0] <= lnk.wr_data;
				gauge_pkg::OFS_CFG_B: cfg_b_r <= lnk.wr_data & gauge_pkg::CFG_B_MASK;
				default: ;
			endcase
		end
	end

	// Learned bit: the device's set beats a host clear in the same cycle
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			learn0_r <= 8'h00;
			learn1_r <= 8'h00;
		end else begin
			if (i_learned[0]) begin
				learn0_r <= gauge_pkg::LEARN_MASK;
			end else if (wr_event && lnk.wr_addr == gauge_pkg::OFS_LEARN0) begin
				learn0_r <= lnk.wr_data & gauge_pkg::LEARN_MASK;
			end
			if (i_learned[1]) begin
				learn1_r <= gauge_pkg::LEARN_MASK;
			end else if (wr_event && lnk.wr_addr == gauge_pkg::OFS_LEARN1) begin
				learn1_r <= lnk.wr_data & gauge_pkg::LEARN_MASK;
			end
		end
	end

	// Snapshot for the link side; held after each toggle so the copy there never tears
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lnk.snap <= {gauge_pkg::CFG_WORD_RST, gauge_pkg::CFG_B_RST, 16'h0000};
			lnk.snap_tgl <= 1'b0;
			snap_hold_r <= 3'h0;
		end else if (snap_hold_r != 3'h0) begin
			snap_hold_r <= snap_hold_r - 3'h1;
		end else if (lnk.snap != {cfg_word_r, cfg_b_r, learn0_r, learn1_r}) begin
			lnk.snap <= {cfg_word_r, cfg_b_r, learn0_r, learn1_r};
			lnk.snap_tgl <= ~lnk.snap_tgl;
			snap_hold_r <= gauge_pkg::SNAP_HOLD;
		end
	end

	// One-second tick paces the relax timers and the cycle averages
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sec_cnt_r <= 32'h0000_0000;
			sec_tick_r <= 1'b0;
		end else if (sec_cnt_r == 32'(SEC_CYCLES_P - 1)) begin
			sec_cnt_r <= 32'h0000_0000;
			sec_tick_r <= 1'b1;
		end else begin
			sec_cnt_r <= sec_cnt_r + 32'h0000_0001;
			sec_tick_r <= 1'b0;
		end
	end

	// Relax entry uses the time of the direction current last flowed in
	assign abs_avg = i_averaged_current[15] ? 16'(-i_averaged_current) : i_averaged_current;
	assign quiet = abs_avg < i_quit_current;
	// N+1 agreeing ticks are needed so the condition has held a full N seconds
	assign enter_now = quiet && (below_r >= (last_chg_r ? i_chg_relax_s : i_dsg_relax_s));
	assign exit_now = !quiet && (above_r >= i_quit_relax_s);

	// Relaxation state and its qualifying counters
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= ST_ACTIVE;
			below_r <= 16'h0000;
			above_r <= 16'h0000;
			relax_secs_r <= 16'h0000;
			last_chg_r <= 1'b0;
		end else if (sec_tick_r) begin
			unique case (state_r)
				ST_ACTIVE: begin
					above_r <= 16'h0000;
					relax_secs_r <= 16'h0000;
					below_r <= quiet ? below_r + 16'h0001 : 16'h0000;
					if (!quiet) begin
						last_chg_r <= !i_averaged_current[15];
					end
					if (enter_now) begin
						state_r <= ST_RELAX;
					end
				end
				ST_RELAX: begin
					below_r <= 16'h0000;
					above_r <= quiet ? 16'h0000 : above_r + 16'h0001;
					if (relax_secs_r != 16'hffff) begin
						relax_secs_r <= relax_secs_r + 16'h0001;
					end
					if (exit_now) begin
						state_r <= ST_ACTIVE;
					end
				end
			endcase
		end
	end

	// OCV window and slope-qualified capacity update
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_relax <= 1'b0;
			o_ocv_attempt <= 1'b0;
			o_qmax_update <= 1'b0;
		end else begin
			o_relax <= state_r == ST_RELAX;
			o_ocv_attempt <= state_r == ST_RELAX && relax_secs_r >= gauge_pkg::OCV_WAIT_S;
			o_qmax_update <= sec_tick_r && o_ocv_attempt
				&& i_dv_dt < gauge_pkg::DVDT_LIMIT_UV;
		end
	end

	// Per-second sums over a discharge; the divide runs once per cycle end
	assign inst_power = i_inst_current * $signed({1'b0, i_voltage});
	assign dsg_end = dsg_prev_r && !i_dsg_active;
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dsg_prev_r <= 1'b0;
			sum_i_r <= '0;
			sum_p_r <= '0;
			samples_r <= 24'h000000;
		end else begin
			dsg_prev_r <= i_dsg_active;
			if (dsg_end) begin
				sum_i_r <= '0;
				sum_p_r <= '0;
				samples_r <= 24'h000000;
			end else if (sec_tick_r && i_dsg_active && samples_r != 24'hffffff) begin
				sum_i_r <= sum_i_r + 40'(i_averaged_current);
				sum_p_r <= sum_p_r + 57'(inst_power);
				samples_r <= samples_r + 24'h000001;
			end
		end
	end

	// Only the device updates the last-run logs
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_avg_i_last <= 16'h0000;
			o_avg_p_last <= 32'h0000_0000;
		end else if (dsg_end && samples_r != 24'h000000) begin
			o_avg_i_last <= 16'(sum_i_r / $signed({16'h0000, samples_r}));
			o_avg_p_last <= 32'(sum_p_r / $signed({33'h0, samples_r}));
		end
	end

	// Low-charge flag holds while remaining capacity equals the threshold
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_low_charge_flag <= 1'b0;
		end else if (i_remaining_cap < i_low_set_thr) begin
			o_low_charge_flag <= 1'b1;
		end else if (i_remaining_cap > i_low_set_thr) begin
			o_low_charge_flag <= 1'b0;
		end
	end

	// Battery detected: own detection or host command, cleared on removal
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_battery_detected_bit <= 1'b0;
		end else if (cfg_b_r[gauge_pkg::B_INSERT] ? i_insert_seen : i_host_det_cmd) begin
			o_battery_detected_bit <= 1'b1;
		end else if (i_batt_removed) begin
			o_battery_detected_bit <= 1'b0;
		end
	end

	// Logical levels of the interrupt and good pins before polarity
	assign irq_active = removal_active
		|| (cfg_word_r[gauge_pkg::B_FIRST_OCV] && i_first_ocv_active);
	assign good_active = i_init_active ? cfg_b_r[gauge_pkg::B_EARLY_GOOD]
		: i_ocv_done
		&& !(i_hibernate && !(cfg_word_r[gauge_pkg::B_OVERRIDE] && i_hib_voltage_only))
		&& !(o_pin_function_code == gauge_pkg::FUNC_MODE1 && i_charging
		&& i_chg_temp_bad);

	// Pin drivers; a cleared polarity bit makes the pin active-low
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_soc_int_out <= 1'b1;
			o_battery_good_out <= 1'b1;
			o_battery_low_out <= 1'b0;
		end else begin
			o_soc_int_out <= cfg_word_r[gauge_pkg::B_IRQ_POL] ? irq_active : !irq_active;
			o_battery_good_out <= cfg_word_r[gauge_pkg::B_GOOD_POL] ? good_active : !good_active;
			o_battery_low_out <= cfg_word_r[gauge_pkg::B_LOW_POL] ? o_low_charge_flag
				: !o_low_charge_flag;
		end
	end

	// Decoded configuration fields, each from a flop
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pin_function_code <= gauge_pkg::FUNC_MODE1;
			o_wake_cfg <= 3'h1;
			o_reserve_comp_en <= 1'b0;
			o_profile_select_en <= 1'b1;
			o_sleep_en <= 1'b1;
			o_capacity_reload_on_term <= 1'b1;
			o_ext_thermistor_sel <= 1'b1;
			o_host_temp_write_en <= 1'b0;
			o_low_batt_irq_en <= 1'b0;
			o_adc_ground_sel <= 1'b1;
			o_thermistor_to_charger <= 1'b0;
		end else begin
			o_pin_function_code <= cfg_word_r[gauge_pkg::B_FUNC_HI:gauge_pkg::B_FUNC_LO];
			o_wake_cfg <= cfg_word_r[gauge_pkg::B_WAKE:gauge_pkg::B_SENSE_LO];
			o_reserve_comp_en <= cfg_word_r[gauge_pkg::B_RESERVE];
			o_profile_select_en <= cfg_word_r[gauge_pkg::B_PROFILE];
			o_sleep_en <= cfg_word_r[gauge_pkg::B_SLEEP];
			o_capacity_reload_on_term <= cfg_word_r[gauge_pkg::B_RELOAD];
			o_ext_thermistor_sel <= cfg_word_r[gauge_pkg::B_THERM];
			o_host_temp_write_en <= cfg_b_r[gauge_pkg::B_HOST_TEMP];
			o_low_batt_irq_en <= cfg_b_r[gauge_pkg::B_LOW_IRQ];
			o_adc_ground_sel <= cfg_b_r[gauge_pkg::B_GROUND];
			o_thermistor_to_charger <= o_pin_function_code == gauge_pkg::FUNC_MODE2
				&& i_charging;
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	a_relax_entry: assert property (state_r == ST_ACTIVE && sec_tick_r && enter_now
		|=> state_r == ST_RELAX) else $error("relax entry missed");
	a_ocv_wait: assert property (o_ocv_attempt |-> relax_secs_r >= 16'h012c)
		else $error("OCV attempt before five minutes");
	a_slope_gate: assert property (o_qmax_update |-> $past(i_dv_dt) < 16'h0004
		&& $past(o_ocv_attempt)) else $error("capacity update without slope");
	a_relax_exit: assert property ($fell(o_relax) |-> $past(exit_now, 2))
		else $error("relax exit without quit time");
	a_learn_set: assert property (i_learned[0] |=> learn0_r == 8'h01)
		else $error("learned bit not set");
	a_avg_log: assert property ($changed(o_avg_i_last) || $changed(o_avg_p_last)
		|-> $past(dsg_end)) else $error("log changed outside cycle end");
	a_removal_pulse: assert property (i_batt_removed && cfg_word_r[13] && !removal_active
		|=> removal_active [*8]) else $error("removal pulse too short");
	a_low_pin: assert property (##1 o_battery_low_out ==
		(($past(cfg_word_r[1])) ? $past(o_low_charge_flag) : !$past(o_low_charge_flag)))
		else $error("low pin wrong");
	a_low_flag: assert property (i_remaining_cap < i_low_set_thr |=> o_low_charge_flag)
		else $error("low flag not set");
	a_early_good: assert property (i_init_active && cfg_b_r[3]
		|=> o_battery_good_out == $past(cfg_word_r[2])) else $error("early good not asserted");

	c_relax: cover property ($rose(o_relax));
	c_qmax: cover property (o_qmax_update);
	c_removal: cover property ($rose(removal_active));
	c_log: cover property (dsg_end && samples_r != 24'h000000);
endmodule
`default_nettype wire

// ==== sim/host_model.sv ====
`default_nettype none
module host_model (
	// Link side of the block
	input wire logic i_link_clk,
	input wire logic i_busy,
	input wire logic [7:0] i_rdata,
	output logic o_wr,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		o_wr = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	// One byte write; learn status is never written in normal use
	// Fields such as host temperature and detection are set only here
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge i_link_clk);
		while (i_busy && n < 300) begin
			@(posedge i_link_clk);
			n++;
		end
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_link_clk);
		o_wr <= 1'b0;
		@(posedge i_link_clk);
		// Busy stays up until the system side acknowledges the byte
		while (i_busy && n < 300) begin
			@(posedge i_link_clk);
			n++;
		end
	endtask
	// Read data is registered, so sample two edges after the address moves
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_link_clk);
		o_addr <= a;
		@(posedge i_link_clk);
		@(posedge i_link_clk);
		d = i_rdata;
	endtask
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr, busy, relax, ocv, low_flag, low_out, good_out, soc_out, detected;
	logic reserve, profile, sleep_en, reload, therm, host_temp, low_irq, ground;
	logic [7:0] addr, wdata, rdata, d;
	logic signed [15:0] avg_i, inst_i;
	logic [15:0] dv_dt, volt, rem_cap, low_thr, quit_rel;
	logic dsg, init_act, first_ocv, ocv_done, hib, hib_v, chg, temp_bad, removed, insert, det_cmd;
	logic [1:0] learned, pin_function_code;
	logic [2:0] wake;
	logic [31:0] seed = 32'ha2a8c6de;
	int bad_count = 0;
	int checks = 0;
	int n;
	always #20 sys_clk = ~sys_clk;
	// Link clock offset so its edges drift against the system clock
	initial begin
		#3;
		forever #7.5 link_clk = ~link_clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Expected pin level of the low output
	function automatic logic low_pin(input logic flag, input logic pol);
		return pol ? flag : !flag;
	endfunction
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (bad_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	host_model u_host (.i_link_clk(link_clk), .i_busy(busy), .i_rdata(rdata), .o_wr(wr),
		.o_addr(addr), .o_wdata(wdata));
	gauge_config_pin_control #(.SEC_CYCLES_P(20), .MS_CYCLES_P(10)) u_dut (
		.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_link_clk(link_clk), .i_link_wr(wr),
		.i_link_addr(addr), .i_link_wdata(wdata), .o_link_rdata(rdata), .o_link_busy(busy),
		.i_averaged_current(avg_i), .i_quit_current(16'h0064), .i_dsg_relax_s(16'h0002),
		.i_chg_relax_s(16'h0002), .i_quit_relax_s(quit_rel), .i_dv_dt(dv_dt),
		.i_inst_current(inst_i), .i_voltage(volt), .i_dsg_active(dsg),
		.i_remaining_cap(rem_cap), .i_low_set_thr(low_thr), .i_learned(learned),
		.i_init_active(init_act), .i_first_ocv_active(first_ocv), .i_ocv_done(ocv_done),
		.i_hibernate(hib), .i_hib_voltage_only(hib_v), .i_charging(chg),
		.i_chg_temp_bad(temp_bad), .i_batt_removed(removed), .i_insert_seen(insert),
		.i_host_det_cmd(det_cmd), .o_relax(relax), .o_ocv_attempt(ocv), .o_qmax_update(),
		.o_avg_i_last(), .o_avg_p_last(), .o_low_charge_flag(low_flag),
		.o_battery_low_out(low_out), .o_battery_good_out(good_out), .o_soc_int_out(soc_out),
		.o_pin_function_code(pin_function_code), .o_wake_cfg(wake), .o_reserve_comp_en(reserve),
		.o_profile_select_en(profile), .o_sleep_en(sleep_en),
		.o_capacity_reload_on_term(reload), .o_ext_thermistor_sel(therm),
		.o_host_temp_write_en(host_temp), .o_low_batt_irq_en(low_irq),
		.o_adc_ground_sel(ground), .o_thermistor_to_charger(), .o_battery_detected_bit(detected));
	// Random measurement traffic keeps the gauge datapath busy during the run
	always @(posedge sys_clk) begin
		if (rst_n) begin
			seed = lfsr(seed);
			inst_i <= seed[15:0];
			volt <= seed[31:16];
			dv_dt <= {12'h000, seed[3:0]};
			{chg, temp_bad, dsg} <= seed[6:4];
		end
	end
	// Hang guard, about eight times the expected six thousand cycles
	initial begin
		#2000000;
		bad_count++;
		print_verdict();
	end
	initial begin
		{dsg, init_act, first_ocv, ocv_done, hib, chg, temp_bad, removed, insert, det_cmd} = '0;
		{learned, dv_dt, volt, inst_i} = '0;
		avg_i = 16'sh0200;
		rem_cap = 16'h0200;
		hib_v = 1'b0;
		low_thr = 16'h0100;
		quit_rel = 16'h0002;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		cyc(2);
		check(pin_function_code, 2'h1);
		check(wake, 3'h1);
		check({reserve, profile, sleep_en, reload, therm}, 5'h0f);
		check({soc_out, good_out, low_out}, 3'h6);
		check({host_temp, low_irq, ground}, 3'h1);
		u_host.rd(8'h00, d);
		check(d, 8'h09);
		u_host.rd(8'h01, d);
		check(d, 8'h73);
		u_host.rd(8'h09, d);
		check(d, 8'h50);
		// Pin function codes 0 to 2 with random neighbours
		for (int k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			d = {seed[7:5], k[1:0], seed[2:0]};
			u_host.wr(8'h00, d);
			cyc(10);
			check(pin_function_code, d[4:3]);
			check(wake, d[2:0]);
			check(reserve, d[7]);
		end
		u_host.wr(8'h09, 8'h2f);
		cyc(10);
		check({host_temp, low_irq, ground}, 3'h2);
		u_host.rd(8'h09, d);
		check(d, 8'h28);
		// Host sets detection while self-detect is off
		det_cmd <= 1'b1;
		cyc(1);
		det_cmd <= 1'b0;
		cyc(3);
		check(detected, 1'b1);
		u_host.wr(8'h00, 8'h29);
		cyc(10);
		removed <= 1'b1;
		cyc(1);
		removed <= 1'b0;
		n = 0;
		repeat (40) begin
			cyc(1);
			n += !soc_out;
		end
		check(n, 10);
		check(detected, 1'b0);
		rem_cap <= 16'h0080;
		cyc(3);
		check(low_flag, 1'b1);
		check(low_out, low_pin(1'b1, 1'b1));
		u_host.wr(8'h01, 8'h71);
		cyc(10);
		check(low_out, low_pin(1'b1, 1'b0));
		rem_cap <= 16'h0200;
		cyc(3);
		check(low_flag, 1'b0);
		check(low_out, low_pin(1'b0, 1'b0));
		// Early good during init, then hibernate with the override off
		init_act <= 1'b1;
		cyc(3);
		check(good_out, 1'b0);
		init_act <= 1'b0;
		{ocv_done, hib, hib_v} <= 3'h7;
		cyc(3);
		check(good_out, 1'b1);
		{ocv_done, hib, hib_v} <= 3'h0;
		learned <= 2'h1;
		cyc(1);
		learned <= 2'h0;
		cyc(10);
		u_host.rd(8'h20, d);
		check(d, 8'h01);
		u_host.rd(8'h21, d);
		check(d, 8'h00);
		u_host.rd(8'h05, d);
		check(d, 8'h00);
		// Relax needs two quiet seconds of 20 cycles each, exit likewise
		check(relax, 1'b0);
		avg_i <= 16'sh0010;
		n = 0;
		while (!relax && n < 300) begin
			cyc(1);
			n++;
		end
		check({relax, n >= 40}, 2'h3);
		// Five relaxed minutes of 20-cycle seconds before OCV readings start
		n = 0;
		while (!ocv && n < 7000) begin
			cyc(1);
			n++;
		end
		check({ocv, n >= int'(gauge_pkg::OCV_WAIT_S) * 20 - 20}, 2'h3);
		check(n <= int'(gauge_pkg::OCV_WAIT_S) * 20 + 20, 1'b1);
		avg_i <= 16'sh0300;
		n = 0;
		while (relax && n < 300) begin
			cyc(1);
			n++;
		end
		check({relax, n >= 40}, 2'h1);
		print_verdict();
	end
endmodule
`default_nettype wire
